// ===== design/sos_status_out.sv
// How it works
// - Reference quantity scales linearly between reference lower and upper limits.
// - Feedback quantity scales linearly between feedback lower and upper limits.
// - Frequency quantity scales linearly from zero to the output frequency maximum.
// - Current quantity scales linearly from zero to the drive rated current.
// - Power quantity reaches full scale at the motor nominal power.
// - Heatsink quantity is span minimum below 20 C, full scale at 100 C.
// - No-function selection leaves the analogue output unused and at zero.
// - Relay closes while the selected condition holds and opens otherwise.
// - Relay selector spans 0 to 32, 0 disables, reset default is 1.
// - Code 1 closes when control card powered and drive ready.
// - Code 2 closes when ready, no start command and no warning.
// - Code 3 closes on start command or frequency above 0.1 Hz.
// - Code 5 closes on start command with no warning active.
// - Code 8 closes on alarm or warning, code 10 only on alarm.
// - Code 9 closes while output current exceeds the current limit setting.
// - Codes 11 to 16 compare frequency, current, feedback against thresholds.
// - Code 18 closes for counterclockwise rotation, opens for clockwise.
// - Code 19 closes on motor or drive overtemperature or hot thermistor.
// - Code 20 closes while local operation is selected.
// - Codes 22 to 24 close when the value leaves its threshold window.
// - Code 26 follows bus control word bit 11 directly.
// - Sleep selection closes while output frequency is below 0.1 Hz.
// - Odd analogue codes use the 0-20 mA span, even codes 4-20 mA.
`timescale 1ns/1ps
`include "sos_regs.svh"
module sos_status_out
#(
  parameter int unsigned P_REFRESH_CYCLES = `SOS_AO_REFRESH_CYC
)
(
  input  wire logic               i_clock,
  input  wire logic               i_sys_rst,
  input  wire logic               i_config_load,
  input  wire logic [`SOS_CW-1:0] i_relay_condition_select,
  input  wire logic [`SOS_AW-1:0] i_analog_out_quantity_select,
  input  wire sos_pkg::sos_status_t i_status,
  input  wire sos_pkg::sos_thresh_t i_thresh,
  input  wire sos_pkg::sos_limits_t i_limits,
  input  wire logic               i_thermistor_pin,
  output logic                    o_relay_closed,
  output logic                    o_relay_code_undefined,
  output logic [`SOS_CW-1:0]      o_relay_code,
  output logic [`SOS_AW-1:0]      o_analog_code,
  output logic [`SOS_VW-1:0]      o_analog_out_ua,
  output logic                    o_analog_out_active,
  output logic                    o_analog_out_update
);
  import sos_pkg::*;

  localparam logic [31:0] REFRESH_LAST = 32'(P_REFRESH_CYCLES - 1);

  // Configuration selectors
  logic [`SOS_CW-1:0] relay_code_q;
  logic [`SOS_AW-1:0] ao_code_q;

  // Thermistor pin synchroniser and settled level
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic therm_q;
  logic thermal_hot;

  // Relay path
  logic relay_cond;
  logic relay_defined;

  // Refresh timebase
  logic [31:0] refresh_cnt_q;
  logic        refresh_tick_q;
  logic        pending_q;

  // Analogue datapath
  sos_ao_state_t      state_q;
  logic [`SOS_VW-1:0] x_q;
  logic [`SOS_VW-1:0] lo_q;
  logic [`SOS_VW-1:0] hi_q;
  logic [`SOS_VW-1:0] span_q;
  logic [`SOS_VW-1:0] base_q;
  logic [`SOS_VW-1:0] result_q;
  logic [`SOS_DW-1:0] num_q;
  logic [`SOS_VW-1:0] den_q;
  logic               active_q;
  logic               div_start_q;
  logic               div_busy;
  logic               div_done;
  logic [`SOS_VW-1:0] div_quotient;
  logic [2:0]         qty;
  logic [`SOS_VW-1:0] sel_x;
  logic [`SOS_VW-1:0] sel_lo;
  logic [`SOS_VW-1:0] sel_hi;
  logic [`SOS_VW-1:0] x_clamped;

  function automatic logic ao_code_valid(input logic [`SOS_AW-1:0] code);
    return (code != `SOS_AO_NONE) && (code <= `SOS_AO_MAX);
  endfunction : ao_code_valid

  function automatic logic [2:0] ao_quantity(input logic [`SOS_AW-1:0] code);
    logic [`SOS_AW-1:0] sum;
    sum = code + 4'h1;
    return sum[3:1];
  endfunction : ao_quantity

  function automatic logic [`SOS_VW-1:0] clamp(input logic [`SOS_VW-1:0] v,
                                               input logic [`SOS_VW-1:0] lo,
                                               input logic [`SOS_VW-1:0] hi);
    logic [`SOS_VW-1:0] r;
    r = v;
    if (v < lo)
      r = lo;
    else if (v > hi)
      r = hi;
    return r;
  endfunction : clamp

  // Selectors load on request only, so a half-written code never reaches the outputs
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      relay_code_q <= `SOS_RLY_RST;
      ao_code_q    <= `SOS_AO_RST;
    end
    else if (i_config_load)
    begin
      relay_code_q <= i_relay_condition_select;
      ao_code_q    <= i_analog_out_quantity_select;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end
    else
    begin
      sync1_q <= i_thermistor_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A contact bouncing for one sample never reaches the relay
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      therm_q <= 1'b0;
    else if (sync2_q == sync3_q)
      therm_q <= sync3_q;
  end

  assign thermal_hot = i_status.motor_overtemp | i_status.drive_overtemp | therm_q;

  sos_relay_decode u_relay_decode
  (
    .i_code        (relay_code_q),
    .i_status      (i_status),
    .i_thresh      (i_thresh),
    .i_thermal_hot (thermal_hot),
    .o_condition   (relay_cond),
    .o_defined     (relay_defined)
  );

  // Relay follows the condition one cycle later
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_relay_closed         <= 1'b0;
      o_relay_code_undefined <= 1'b0;
      o_relay_code           <= `SOS_RLY_RST;
      o_analog_code          <= `SOS_AO_RST;
    end
    else
    begin
      o_relay_closed         <= relay_cond & relay_defined;
      o_relay_code_undefined <= ~relay_defined;
      o_relay_code           <= relay_code_q;
      o_analog_code          <= ao_code_q;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      refresh_cnt_q  <= '0;
      refresh_tick_q <= 1'b0;
    end
    else if (refresh_cnt_q >= REFRESH_LAST)
    begin
      refresh_cnt_q  <= '0;
      refresh_tick_q <= 1'b1;
    end
    else
    begin
      refresh_cnt_q  <= refresh_cnt_q + 32'h1;
      refresh_tick_q <= 1'b0;
    end
  end

  // New request wins over the clear taken when a conversion starts
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      pending_q <= 1'b1;
    else if (refresh_tick_q || i_config_load)
      pending_q <= 1'b1;
    else if (state_q == AO_IDLE)
      pending_q <= 1'b0;
  end

  assign qty = ao_quantity(ao_code_q);

  always_comb
  begin
    sel_x  = '0;
    sel_lo = '0;
    sel_hi = '0;
    case (qty)
      `SOS_QTY_REF:
      begin
        sel_x  = i_status.reference;
        sel_lo = i_limits.reference_lower_limit;
        sel_hi = i_limits.reference_upper_limit;
      end
      `SOS_QTY_FB:
      begin
        sel_x  = i_status.feedback;
        sel_lo = i_limits.feedback_lower_limit;
        sel_hi = i_limits.feedback_upper_limit;
      end
      `SOS_QTY_FREQ:
      begin
        sel_x  = i_status.out_freq;
        sel_hi = i_limits.output_freq_max;
      end
      `SOS_QTY_CUR:
      begin
        sel_x  = i_status.out_current;
        sel_hi = i_limits.rated_current;
      end
      `SOS_QTY_PWR:
      begin
        sel_x  = i_status.out_power;
        sel_hi = i_limits.motor_nominal_power;
      end
      `SOS_QTY_TEMP:
      begin
        sel_x  = {{(`SOS_VW-`SOS_TW){1'b0}}, i_status.heatsink_temp};
        sel_lo = `SOS_TEMP_LO;
        sel_hi = `SOS_TEMP_HI;
      end
      default:
      begin
        sel_x  = '0;
        sel_lo = '0;
        sel_hi = '0;
      end
    endcase
  end

  // Below the low point the clamp pins the value to the span minimum
  assign x_clamped = clamp(x_q, lo_q, hi_q);

  sos_ao_divider u_ao_divider
  (
    .i_clock    (i_clock),
    .i_sys_rst  (i_sys_rst),
    .i_start    (div_start_q),
    .i_dividend (num_q),
    .i_divisor  (den_q),
    .o_busy     (div_busy),
    .o_done     (div_done),
    .o_quotient (div_quotient)
  );

  // Conversion sequencer; a sample taken at SELECT is held through the divide
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_q     <= AO_IDLE;
      x_q         <= '0;
      lo_q        <= '0;
      hi_q        <= '0;
      span_q      <= '0;
      base_q      <= '0;
      result_q    <= '0;
      num_q       <= '0;
      den_q       <= '0;
      active_q    <= 1'b0;
      div_start_q <= 1'b0;
    end
    else
    begin
      div_start_q <= 1'b0;
      case (state_q)
        AO_IDLE:
        begin
          if (pending_q && !div_busy)
            state_q <= AO_SELECT;
        end
        AO_SELECT:
        begin
          x_q      <= sel_x;
          lo_q     <= sel_lo;
          hi_q     <= sel_hi;
          result_q <= '0;
          active_q <= ao_code_valid(ao_code_q);
          if (!ao_code_valid(ao_code_q))
          begin
            span_q  <= `SOS_UA_SPAN_ZERO;
            base_q  <= `SOS_UA_ZERO;
            state_q <= AO_UPDATE;
          end
          else if (ao_code_q[0])
          begin
            span_q  <= `SOS_UA_SPAN_ZERO;
            base_q  <= `SOS_UA_ZERO;
            state_q <= AO_PRODUCT;
          end
          else
          begin
            span_q  <= `SOS_UA_SPAN_LIVE;
            base_q  <= `SOS_UA_LIVE_ZERO;
            state_q <= AO_PRODUCT;
          end
        end
        AO_PRODUCT:
        begin
          // A collapsed or inverted window acts as a step at the upper limit
          if (hi_q <= lo_q)
          begin
            result_q <= (x_q >= hi_q) ? span_q : '0;
            state_q  <= AO_UPDATE;
          end
          else
          begin
            num_q   <= (x_clamped - lo_q) * span_q;
            den_q   <= hi_q - lo_q;
            state_q <= AO_DIVIDE;
          end
        end
        AO_DIVIDE:
        begin
          div_start_q <= 1'b1;
          state_q     <= AO_WAIT;
        end
        AO_WAIT:
        begin
          if (div_done)
          begin
            result_q <= div_quotient;
            state_q  <= AO_UPDATE;
          end
        end
        AO_UPDATE:
        begin
          state_q <= AO_IDLE;
        end
        default:
        begin
          state_q <= AO_IDLE;
        end
      endcase
    end
  end

  // Output changes only as a whole, never mid-conversion
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_analog_out_ua     <= `SOS_UA_ZERO;
      o_analog_out_active <= 1'b0;
      o_analog_out_update <= 1'b0;
    end
    else if (state_q == AO_UPDATE)
    begin
      o_analog_out_ua     <= active_q ? base_q + result_q : `SOS_UA_ZERO;
      o_analog_out_active <= active_q;
      o_analog_out_update <= 1'b1;
    end
    else
    begin
      o_analog_out_update <= 1'b0;
    end
  end

endmodule : sos_status_out

// ===== design/sos_regs.svh
`ifndef SOS_REGS_SVH
`define SOS_REGS_SVH

// Widths
`define SOS_VW 16
`define SOS_TW 8
`define SOS_CW 6
`define SOS_AW 4
`define SOS_DW 32

// Relay condition codes
`define SOS_RLY_NONE          6'h00
`define SOS_RLY_READY         6'h01
`define SOS_RLY_ENABLE_NOWARN 6'h02
`define SOS_RLY_RUNNING       6'h03
`define SOS_RLY_RUN_ON_REF    6'h04
`define SOS_RLY_RUN_NOWARN    6'h05
`define SOS_RLY_RUN_IN_RANGE  6'h06
`define SOS_RLY_READY_SUPPLY  6'h07
`define SOS_RLY_ALARM_OR_WARN 6'h08
`define SOS_RLY_CURRENT_LIMIT 6'h09
`define SOS_RLY_ALARM         6'h0a
`define SOS_RLY_ABOVE_FREQ_LO 6'h0b
`define SOS_RLY_BELOW_FREQ_HI 6'h0c
`define SOS_RLY_ABOVE_CUR_LO  6'h0d
`define SOS_RLY_BELOW_CUR_HI  6'h0e
`define SOS_RLY_ABOVE_FB_LO   6'h0f
`define SOS_RLY_BELOW_FB_HI   6'h10
`define SOS_RLY_REVERSE       6'h12
`define SOS_RLY_THERMAL       6'h13
`define SOS_RLY_LOCAL         6'h14
`define SOS_RLY_OUT_FREQ      6'h16
`define SOS_RLY_OUT_CUR       6'h17
`define SOS_RLY_OUT_FB        6'h18
`define SOS_RLY_CW_BIT11      6'h1a
`define SOS_RLY_SLEEP         6'h1b
`define SOS_RLY_CW_BIT12      6'h1f
`define SOS_RLY_SLEEP_ALT     6'h20
`define SOS_RLY_RST           6'h01

// Analogue output quantity codes
`define SOS_AO_NONE 4'h0
`define SOS_AO_MAX  4'hc
`define SOS_AO_RST  4'h7
`define SOS_QTY_REF  3'h1
`define SOS_QTY_FB   3'h2
`define SOS_QTY_FREQ 3'h3
`define SOS_QTY_CUR  3'h4
`define SOS_QTY_PWR  3'h5
`define SOS_QTY_TEMP 3'h6

// Loop current in microamps
`define SOS_UA_ZERO       16'h0000
`define SOS_UA_LIVE_ZERO  16'h0fa0
`define SOS_UA_FULL       16'h4e20
`define SOS_UA_SPAN_ZERO  16'h4e20
`define SOS_UA_SPAN_LIVE  16'h3e80

// Heatsink scale points in degrees C, frequency LSB is 0.1 Hz
`define SOS_TEMP_LO   16'h0014
`define SOS_TEMP_HI   16'h0064
`define SOS_FREQ_MIN  16'h0001
`define SOS_CW_RLY_A  11
`define SOS_CW_RLY_B  12

// Timing
`define SOS_CLK_MHZ         100
`define SOS_AO_REFRESH_US   1000
`define SOS_AO_REFRESH_CYC  (`SOS_AO_REFRESH_US * `SOS_CLK_MHZ)

`endif

// ===== design/sos_pkg.sv
package sos_pkg;
`include "sos_regs.svh"

  typedef struct packed {
    logic                control_powered;
    logic                drive_ready;
    logic                start_cmd;
    logic                warning;
    logic                alarm;
    logic                rotation_ccw;
    logic                motor_overtemp;
    logic                drive_overtemp;
    logic                local_mode;
    logic                on_reference;
    logic                ready_supply_in_range;
    logic [15:0]         control_word;
    logic [`SOS_VW-1:0]  out_freq;
    logic [`SOS_VW-1:0]  out_current;
    logic [`SOS_VW-1:0]  feedback;
    logic [`SOS_VW-1:0]  reference;
    logic [`SOS_VW-1:0]  out_power;
    logic [`SOS_TW-1:0]  heatsink_temp;
  } sos_status_t;

  typedef struct packed {
    logic [`SOS_VW-1:0] frequency_low_threshold;
    logic [`SOS_VW-1:0] frequency_high_threshold;
    logic [`SOS_VW-1:0] current_low_threshold;
    logic [`SOS_VW-1:0] current_high_threshold;
    logic [`SOS_VW-1:0] feedback_low_threshold;
    logic [`SOS_VW-1:0] feedback_high_threshold;
    logic [`SOS_VW-1:0] current_limit_setting;
  } sos_thresh_t;

  typedef struct packed {
    logic [`SOS_VW-1:0] reference_lower_limit;
    logic [`SOS_VW-1:0] reference_upper_limit;
    logic [`SOS_VW-1:0] feedback_lower_limit;
    logic [`SOS_VW-1:0] feedback_upper_limit;
    logic [`SOS_VW-1:0] output_freq_max;
    logic [`SOS_VW-1:0] rated_current;
    logic [`SOS_VW-1:0] motor_nominal_power;
  } sos_limits_t;

  typedef enum logic [2:0] {
    AO_IDLE,
    AO_SELECT,
    AO_PRODUCT,
    AO_DIVIDE,
    AO_WAIT,
    AO_UPDATE
  } sos_ao_state_t;

endpackage : sos_pkg

// ===== design/sos_relay_decode.sv
`timescale 1ns/1ps
`include "sos_regs.svh"
module sos_relay_decode
(
  input  wire logic [`SOS_CW-1:0] i_code,
  input  wire sos_pkg::sos_status_t i_status,
  input  wire sos_pkg::sos_thresh_t i_thresh,
  input  wire logic               i_thermal_hot,
  output logic                    o_condition,
  output logic                    o_defined
);
  import sos_pkg::*;

  function automatic logic above(input logic [`SOS_VW-1:0] v, input logic [`SOS_VW-1:0] t);
    return v > t;
  endfunction : above

  function automatic logic below(input logic [`SOS_VW-1:0] v, input logic [`SOS_VW-1:0] t);
    return v < t;
  endfunction : below

  function automatic logic outside(input logic [`SOS_VW-1:0] v,
                                   input logic [`SOS_VW-1:0] lo,
                                   input logic [`SOS_VW-1:0] hi);
    return below(v, lo) | above(v, hi);
  endfunction : outside

  always_comb
  begin
    o_condition = 1'b0;
    o_defined   = 1'b1;
    case (i_code)
      `SOS_RLY_NONE:          o_condition = 1'b0;
      `SOS_RLY_READY:         o_condition = i_status.control_powered & i_status.drive_ready;
      `SOS_RLY_ENABLE_NOWARN: o_condition = i_status.drive_ready & ~i_status.start_cmd
                                            & ~i_status.warning;
      `SOS_RLY_RUNNING:       o_condition = i_status.start_cmd
                                            | above(i_status.out_freq, `SOS_FREQ_MIN);
      `SOS_RLY_RUN_ON_REF,
      `SOS_RLY_RUN_IN_RANGE:  o_condition = i_status.start_cmd & i_status.on_reference
                                            & ~i_status.warning;
      `SOS_RLY_RUN_NOWARN:    o_condition = i_status.start_cmd & ~i_status.warning;
      `SOS_RLY_READY_SUPPLY:  o_condition = i_status.ready_supply_in_range & i_status.drive_ready
                                            & i_status.control_powered & ~i_status.start_cmd;
      `SOS_RLY_ALARM_OR_WARN: o_condition = i_status.alarm | i_status.warning;
      `SOS_RLY_ALARM:         o_condition = i_status.alarm;
      `SOS_RLY_CURRENT_LIMIT: o_condition = above(i_status.out_current,
                                                  i_thresh.current_limit_setting);
      `SOS_RLY_ABOVE_FREQ_LO: o_condition = above(i_status.out_freq,
                                                  i_thresh.frequency_low_threshold);
      `SOS_RLY_BELOW_FREQ_HI: o_condition = below(i_status.out_freq,
                                                  i_thresh.frequency_high_threshold);
      `SOS_RLY_ABOVE_CUR_LO:  o_condition = above(i_status.out_current,
                                                  i_thresh.current_low_threshold);
      `SOS_RLY_BELOW_CUR_HI:  o_condition = below(i_status.out_current,
                                                  i_thresh.current_high_threshold);
      `SOS_RLY_ABOVE_FB_LO:   o_condition = above(i_status.feedback,
                                                  i_thresh.feedback_low_threshold);
      `SOS_RLY_BELOW_FB_HI:   o_condition = below(i_status.feedback,
                                                  i_thresh.feedback_high_threshold);
      `SOS_RLY_REVERSE:       o_condition = i_status.rotation_ccw;
      `SOS_RLY_THERMAL:       o_condition = i_thermal_hot;
      `SOS_RLY_LOCAL:         o_condition = i_status.local_mode;
      `SOS_RLY_OUT_FREQ:      o_condition = outside(i_status.out_freq,
                                                    i_thresh.frequency_low_threshold,
                                                    i_thresh.frequency_high_threshold);
      `SOS_RLY_OUT_CUR:       o_condition = outside(i_status.out_current,
                                                    i_thresh.current_low_threshold,
                                                    i_thresh.current_high_threshold);
      `SOS_RLY_OUT_FB:        o_condition = outside(i_status.feedback,
                                                    i_thresh.feedback_low_threshold,
                                                    i_thresh.feedback_high_threshold);
      `SOS_RLY_CW_BIT11:      o_condition = i_status.control_word[`SOS_CW_RLY_A];
      `SOS_RLY_CW_BIT12:      o_condition = i_status.control_word[`SOS_CW_RLY_B];
      `SOS_RLY_SLEEP,
      `SOS_RLY_SLEEP_ALT:     o_condition = below(i_status.out_freq, `SOS_FREQ_MIN);
      default:                o_defined   = 1'b0;
    endcase
  end

endmodule : sos_relay_decode

// ===== design/sos_ao_divider.sv
`timescale 1ns/1ps
`include "sos_regs.svh"
module sos_ao_divider
(
  input  wire logic               i_clock,
  input  wire logic               i_sys_rst,
  input  wire logic               i_start,
  input  wire logic [`SOS_DW-1:0] i_dividend,
  input  wire logic [`SOS_VW-1:0] i_divisor,
  output logic                    o_busy,
  output logic                    o_done,
  output logic [`SOS_VW-1:0]      o_quotient
);
  import sos_pkg::*;

  // One quotient bit per cycle keeps the datapath to a single subtractor
  logic [`SOS_DW-1:0] num_q;
  logic [`SOS_DW-1:0] quo_q;
  logic [`SOS_VW-1:0] rem_q;
  logic [`SOS_VW-1:0] div_q;
  logic [5:0]         cnt_q;
  logic [`SOS_VW:0]   trial;
  logic               fits;

  always_comb
  begin
    trial = {rem_q, num_q[`SOS_DW-1]};
    fits  = trial >= {1'b0, div_q};
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      num_q  <= '0;
      quo_q  <= '0;
      rem_q  <= '0;
      div_q  <= '0;
      cnt_q  <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start && !o_busy)
      begin
        num_q  <= i_dividend;
        div_q  <= i_divisor;
        quo_q  <= '0;
        rem_q  <= '0;
        cnt_q  <= 6'h20;
        o_busy <= 1'b1;
      end
      else if (o_busy)
      begin
        num_q <= {num_q[`SOS_DW-2:0], 1'b0};
        quo_q <= {quo_q[`SOS_DW-2:0], fits};
        rem_q <= fits ? trial[`SOS_VW-1:0] - div_q : trial[`SOS_VW-1:0];
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01)
        begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end

  // Caller keeps the quotient at or below full scale, so the low half holds it
  assign o_quotient = quo_q[`SOS_VW-1:0];

endmodule : sos_ao_divider

// ===== sim/sos_status_out_monitor.sv
`timescale 1ns/1ps
module sos_status_out_monitor
#(
  parameter int unsigned P_REFRESH_CYCLES = 64
)
(
  input  wire logic                i_clock,
  input  wire logic                i_sys_rst,
  input  wire logic                i_config_load,
  input  wire logic [5:0]          i_relay_condition_select,
  input  wire sos_pkg::sos_status_t i_status,
  input  wire logic                o_relay_closed,
  input  wire logic [5:0]          o_relay_code,
  input  wire logic [15:0]         o_analog_out_ua,
  input  wire logic                o_analog_out_active
);
  import sos_pkg::*;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);
  property p_ld;
    i_config_load |=> ##1 o_relay_code == $past(i_relay_condition_select, 2);
  endproperty
  a_ld: assert property (p_ld) else $error("relay code not loaded");
  property p_run;
    o_relay_code == 6'h03 |->
      o_relay_closed == $past(i_status.start_cmd || i_status.out_freq > 16'h0001);
  endproperty
  a_run: assert property (p_run) else $error("running wrong");
  property p_al;
    o_relay_code == 6'h0a |-> o_relay_closed == $past(i_status.alarm);
  endproperty
  a_al: assert property (p_al) else $error("alarm wrong");
  property p_rev;
    o_relay_code == 6'h12 |-> o_relay_closed == $past(i_status.rotation_ccw);
  endproperty
  a_rev: assert property (p_rev) else $error("reverse wrong");
  property p_cw;
    o_relay_code == 6'h1a |-> o_relay_closed == $past(i_status.control_word[11]);
  endproperty
  a_cw: assert property (p_cw) else $error("control bit wrong");
  property p_slp;
    o_relay_code == 6'h1b |-> o_relay_closed == $past(i_status.out_freq < 16'h0001);
  endproperty
  a_slp: assert property (p_slp) else $error("sleep wrong");
  property p_und;
    o_relay_code == 6'h15 |-> !o_relay_closed;
  endproperty
  a_und: assert property (p_und) else $error("undefined code closed relay");
  property p_nf;
    !o_analog_out_active |-> o_analog_out_ua == 16'h0000;
  endproperty
  a_nf: assert property (p_nf) else $error("idle output not zero");
endmodule : sos_status_out_monitor
bind sos_status_out sos_status_out_monitor #(.P_REFRESH_CYCLES(P_REFRESH_CYCLES)) u_mon (
  .i_clock, .i_sys_rst, .i_config_load, .i_relay_condition_select, .i_status,
  .o_relay_closed, .o_relay_code, .o_analog_out_ua, .o_analog_out_active);

// ===== sim/sos_relay_load.sv
`timescale 1ns/1ps
module sos_relay_load
(
  input  wire logic i_relay_closed,
  output logic      o_contact
);
  // Contact bounce is not modelled, so the load mirrors the coil at once
  assign o_contact = i_relay_closed;
endmodule : sos_relay_load

// ===== sim/test_sos_status_out.sv
`timescale 1ns/1ps
module test_sos_status_out;
  import sos_pkg::*;
  logic         clk = 0;
  logic         rst = 1;
  logic         ld = 0;
  logic [5:0]   rsel = 6'h00;
  logic [3:0]   asel = 4'h7;
  logic         therm = 0;
  sos_status_t  s = '0;
  sos_thresh_t  th = '0;
  sos_limits_t  lm = '0;
  logic         rly, act, upd, contact;
  logic [5:0]   rcode;
  logic [3:0]   acode;
  logic [15:0]  ua;
  logic [127:0] r;
  int           failures = 0;
  int           checks = 0;
  int           seed = 10;
  int           cyc = 0;
  logic [16:0]  aq[$];
  logic         rq[$];
  // Refresh pushed past the run so every update after the one reset requests comes from a load
  sos_status_out #(.P_REFRESH_CYCLES(50000)) dut (.i_clock(clk), .i_sys_rst(rst),
    .i_config_load(ld), .i_relay_condition_select(rsel), .i_analog_out_quantity_select(asel),
    .i_status(s), .i_thresh(th), .i_limits(lm), .i_thermistor_pin(therm),
    .o_relay_closed(rly), .o_relay_code_undefined(), .o_relay_code(rcode),
    .o_analog_code(acode), .o_analog_out_ua(ua), .o_analog_out_active(act),
    .o_analog_out_update(upd));
  sos_relay_load u_load (.i_relay_closed(rly), .o_contact(contact));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task final_report;
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  function automatic logic rx(logic [5:0] c);
    logic [15:0] f;
    logic [15:0] i;
    logic [15:0] b;
    f = s.out_freq;
    i = s.out_current;
    b = s.feedback;
    case (c)
      6'h01: return s.control_powered & s.drive_ready;
      6'h02: return s.drive_ready & !s.start_cmd & !s.warning;
      6'h03: return s.start_cmd | (f > 16'h0001);
      6'h04, 6'h06: return s.start_cmd & s.on_reference & !s.warning;
      6'h05: return s.start_cmd & !s.warning;
      6'h07: return s.ready_supply_in_range & s.drive_ready & s.control_powered & !s.start_cmd;
      6'h08: return s.alarm | s.warning;
      6'h09: return i > th[15:0];
      6'h0a: return s.alarm;
      6'h0b: return f > th[111:96];
      6'h0c: return f < th[95:80];
      6'h0d: return i > th[79:64];
      6'h0e: return i < th[63:48];
      6'h0f: return b > th[47:32];
      6'h10: return b < th[31:16];
      6'h12: return s.rotation_ccw;
      6'h13: return s.motor_overtemp | s.drive_overtemp | therm;
      6'h14: return s.local_mode;
      6'h16: return f < th[111:96] || f > th[95:80];
      6'h17: return i < th[79:64] || i > th[63:48];
      6'h18: return b < th[47:32] || b > th[31:16];
      6'h1a: return s.control_word[11];
      6'h1b, 6'h20: return f < 16'h0001;
      6'h1f: return s.control_word[12];
      default: return 1'b0;
    endcase
  endfunction : rx
  always @(negedge clk)
    if (rq.size() > 0)
      chk({16'h0, contact}, {16'h0, rq.pop_front()});
  always @(posedge clk)
    if (upd && aq.size() > 0)
      chk({act, ua}, aq.pop_front());
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      final_report();
    end
  end
  initial
  begin
    s.control_powered = 1;
    s.drive_ready = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    repeat (3) @(negedge clk);
    chk({6'h0, rly, rcode, acode}, {6'h0, 1'b1, 6'h01, 4'h7});
    repeat (3)
      for (int c = 0; c < 34; c++)
      begin
        r = {$random(seed), $random(seed), $random(seed), $random(seed)};
        s = r[114:0];
        // Half the time keep frequency near zero so sleep and running both flip
        if (r[127])
          s.out_freq = {14'h0, r[126:125]};
        th = {r[63:0], r[127:80]};
        therm = r[120];
        rsel = c[5:0];
        ld = 1;
        @(negedge clk);
        ld = 0;
        // Covers load, relay register and the thermistor synchroniser
        repeat (7) @(negedge clk);
        rq.push_back(rx(rsel));
        @(negedge clk);
      end
    // Let conversions started by the relay loads drain
    repeat (100) @(negedge clk);
    s.reference = 16'h0046;
    s.feedback = 16'h003c;
    s.out_freq = 16'h0032;
    s.out_current = 16'h0032;
    s.out_power = 16'h0032;
    s.heatsink_temp = 8'h3c;
    lm = {16'h0014, 16'h0078, 16'h000a, 16'h006e, 16'h0064, 16'h0064, 16'h0064};
    for (int c = 0; c < 14; c++)
    begin
      asel = c[3:0];
      ld = 1;
      aq.push_back((c == 0 || c > 12) ? 17'h0 : {1'b1, c[0] ? 16'h2710 : 16'h2ee0});
      @(negedge clk);
      ld = 0;
      @(posedge clk iff upd);
      @(negedge clk);
    end
    final_report();
  end
endmodule : test_sos_status_out
